// ---- design/gmr_pkg.sv ----
// Shared constants and types for the reduced-power sequencer ends
package gmr_pkg;

    // ==================================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    // Source transition wait, in microseconds
    localparam int SOURCE_TRANSITION_WAIT_US = 25;
    localparam int SOURCE_TRANSITION_WAIT_CYC = SOURCE_TRANSITION_WAIT_US * 1000 / CLK_PERIOD_NS;
    // Source ready time, in microseconds
    localparam int SOURCE_READY_TIME_US = 285;
    localparam int SOURCE_READY_TIME_CYC = SOURCE_READY_TIME_US * 1000 / CLK_PERIOD_NS;
    // Sink new power time, in microseconds
    localparam int SINK_NEW_POWER_TIME_US = 15;
    localparam int SINK_NEW_POWER_TIME_CYC = SINK_NEW_POWER_TIME_US * 1000 / CLK_PERIOD_NS;
    // Supply transition timer, in microseconds
    localparam int SUPPLY_TRANSITION_TIMER_US = 500;
    localparam int SUPPLY_TRANSITION_TIMER_CYC =
        SUPPLY_TRANSITION_TIMER_US * 1000 / CLK_PERIOD_NS;
    // New sink settle time, in microseconds
    localparam int NEW_SINK_SETTLE_TIME_US = 15;
    localparam int NEW_SINK_SETTLE_TIME_CYC = NEW_SINK_SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
    // Source off supervision timer, in microseconds
    localparam int SOURCE_OFF_SUPERVISION_TIMER_US = 800;
    localparam int SOURCE_OFF_SUPERVISION_TIMER_CYC =
        SOURCE_OFF_SUPERVISION_TIMER_US * 1000 / CLK_PERIOD_NS;
    localparam int TIMER_W = 32;

    // ==================================================================
    // Message codes on the link
    typedef enum logic [1:0] {
        MSG_NONE = 2'h0,
        MSG_GOTO_MIN = 2'h1,
        MSG_PS_READY = 2'h2
    } gmr_msg_t;

endpackage : gmr_pkg

// ---- design/gmr_link_if.sv ----
// Message link between the source-side and sink-side policy engines
`timescale 1ns/1ps
interface gmr_link_if;
    import gmr_pkg::*;
    // Source to sink message and good-CRC reply back
    logic src_msg_valid;
    gmr_msg_t src_msg;
    logic snk_ack;
    // One modport per end; only the source sends messages in this sequence
    modport source (output src_msg_valid, output src_msg, input snk_ack);
    modport sink (input src_msg_valid, input src_msg, output snk_ack);
endinterface : gmr_link_if

// ---- design/gmr_sink_pe.sv ----
// Sink-side policy engine for the reduced-power sequence and swap settle
`timescale 1ns/1ps
module gmr_sink_pe
    import gmr_pkg::*;
#(
    parameter int TRANSITION_CYC = SUPPLY_TRANSITION_TIMER_CYC,
    parameter int NEW_POWER_CYC = SINK_NEW_POWER_TIME_CYC,
    parameter int SETTLE_CYC = NEW_SINK_SETTLE_TIME_CYC,
    parameter int SRC_OFF_CYC = SOURCE_OFF_SUPERVISION_TIMER_CYC
)(
    input wire logic CORE_CLK,
    input wire logic NRST,
    gmr_link_if.sink LINK,
    input wire logic SWAP_ACTIVE,
    input wire logic SUPPLY_DONE,
    output logic REDUCE_CMD,
    output logic SETTLE_CMD,
    output logic SINK_ROLE_READY,
    output logic TRANSITION_ERR,
    output logic SEQ_DONE
);
    import gmr_pkg::*;

    // ==================================================================
    // State machine
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_EVAL = 5'h02,
        S_REDUCE = 5'h04,
        S_WAIT_RDY = 5'h08,
        S_SETTLE = 5'h10
    } gmr_snk_state_t;

    gmr_snk_state_t state_q, state_d;
    logic [TIMER_W-1:0] tmr_q, tmr_d;
    logic [TIMER_W-1:0] load_q, load_d;
    logic err_q, err_d;
    logic done_q, done_d;
    logic red_q, red_d;
    logic set_q, set_d;
    logic role_q, role_d;
    logic got_min, got_rdy;

    assign got_min = LINK.src_msg_valid && (LINK.src_msg == MSG_GOTO_MIN);
    assign got_rdy = LINK.src_msg_valid && (LINK.src_msg == MSG_PS_READY);
    // Good-CRC reply given combinationally for every valid message
    assign LINK.snk_ack = LINK.src_msg_valid;

    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        load_d = (load_q != '0) ? load_q - 1'b1 : load_q;
        err_d = 1'b0;
        done_d = 1'b0;
        red_d = red_q;
        set_d = set_q;
        role_d = role_q;
        case (state_q)
            S_IDLE:
            begin
                if (got_min)
                begin
                    tmr_d = TIMER_W'(TRANSITION_CYC);
                    state_d = S_EVAL;
                end
                else if (got_rdy && SWAP_ACTIVE)
                begin
                    // Supervision stops on ready; settle timer starts
                    tmr_d = '0;
                    load_d = TIMER_W'(SETTLE_CYC);
                    set_d = 1'b1;
                    role_d = 1'b0;
                    state_d = S_SETTLE;
                end
            end
            S_EVAL:
            begin
                // One cycle to evaluate after the ack
                red_d = 1'b1;
                load_d = TIMER_W'(NEW_POWER_CYC);
                state_d = S_REDUCE;
            end
            S_REDUCE:
            begin
                if (SUPPLY_DONE || load_q == '0)
                begin
                    red_d = 1'b0;
                    state_d = S_WAIT_RDY;
                end
            end
            S_WAIT_RDY:
            begin
                if (got_rdy)
                begin
                    tmr_d = '0;
                    done_d = 1'b1;
                    state_d = S_IDLE;
                end
                else if (tmr_q == '0)
                begin
                    err_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_SETTLE:
            begin
                // Load-dependent: supply reports when done, bounded by settle time
                if (SUPPLY_DONE || load_q == '0)
                begin
                    set_d = 1'b0;
                    role_d = 1'b1;
                    done_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
        if (state_q == S_IDLE && got_min)
            role_d = role_q;
    end

    // Registers
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= S_IDLE;
            tmr_q <= '0;
            load_q <= '0;
            err_q <= 1'b0;
            done_q <= 1'b0;
            red_q <= 1'b0;
            set_q <= 1'b0;
            role_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            load_q <= load_d;
            err_q <= err_d;
            done_q <= done_d;
            red_q <= red_d;
            set_q <= set_d;
            role_q <= role_d;
        end
    end

    assign REDUCE_CMD = red_q;
    assign SETTLE_CMD = set_q;
    assign SINK_ROLE_READY = role_q;
    assign TRANSITION_ERR = err_q;
    assign SEQ_DONE = done_q;

    // SRC_OFF_CYC reserved for the earlier swap steps handled elsewhere
    localparam int UNUSED_SRC_OFF = SRC_OFF_CYC;

endmodule : gmr_sink_pe

// ---- design/gmr_source_pe.sv ----
// Source-side policy engine for the reduced-power sequence
`timescale 1ns/1ps
module gmr_source_pe
    import gmr_pkg::*;
#(
    parameter int WAIT_CYC = SOURCE_TRANSITION_WAIT_CYC,
    parameter int READY_CYC = SOURCE_READY_TIME_CYC
)(
    input wire logic CORE_CLK,
    input wire logic NRST,
    gmr_link_if.source LINK,
    input wire logic START,
    input wire logic SUPPLY_READY,
    output logic SUPPLY_CHANGE_CMD,
    output logic READY_TIMEOUT,
    output logic BUSY,
    output logic SEQ_DONE
);
    import gmr_pkg::*;

    // ==================================================================
    // State machine, one-hot
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_SEND_MIN = 6'h02,
        S_WAIT = 6'h04,
        S_CHANGE = 6'h08,
        S_SEND_RDY = 6'h10,
        S_DONE = 6'h20
    } gmr_src_state_t;

    gmr_src_state_t state_q, state_d;
    logic [TIMER_W-1:0] tmr_q, tmr_d;
    logic cmd_q, cmd_d;
    logic tout_q, tout_d;
    logic done_q, done_d;

    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        cmd_d = cmd_q;
        tout_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                if (START)
                    state_d = S_SEND_MIN;
            end
            S_SEND_MIN:
            begin
                // Message held until the good-CRC reply
                if (LINK.snk_ack)
                begin
                    tmr_d = TIMER_W'(WAIT_CYC);
                    state_d = S_WAIT;
                end
            end
            S_WAIT:
            begin
                if (tmr_q == '0)
                begin
                    cmd_d = 1'b1;
                    tmr_d = TIMER_W'(READY_CYC);
                    state_d = S_CHANGE;
                end
            end
            S_CHANGE:
            begin
                if (SUPPLY_READY)
                begin
                    cmd_d = 1'b0;
                    state_d = S_SEND_RDY;
                end
                else if (tmr_q == '0)
                begin
                    // Flag late supply but keep waiting; it may still arrive
                    tout_d = 1'b1;
                    tmr_d = TIMER_W'(READY_CYC);
                end
            end
            S_SEND_RDY:
            begin
                if (LINK.snk_ack)
                begin
                    done_d = 1'b1;
                    state_d = S_DONE;
                end
            end
            S_DONE:
            begin
                state_d = S_IDLE;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_q <= S_IDLE;
            tmr_q <= '0;
            cmd_q <= 1'b0;
            tout_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            cmd_q <= cmd_d;
            tout_q <= tout_d;
            done_q <= done_d;
        end
    end

    // Message outputs decoded from state
    assign LINK.src_msg_valid = (state_q == S_SEND_MIN) || (state_q == S_SEND_RDY);
    assign LINK.src_msg = (state_q == S_SEND_MIN) ? MSG_GOTO_MIN :
                          (state_q == S_SEND_RDY) ? MSG_PS_READY : MSG_NONE;
    assign SUPPLY_CHANGE_CMD = cmd_q;
    assign READY_TIMEOUT = tout_q;
    assign BUSY = (state_q != S_IDLE);
    assign SEQ_DONE = done_q;

endmodule : gmr_source_pe

// ---- test/gmr_link_checker.sv ----
// Assertions and covers on the message link between the two engines
`timescale 1ns/1ps
module gmr_link_checker
    import gmr_pkg::*;
#(
    parameter int WAIT_CYC = 4
)(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic src_msg_valid,
    input wire gmr_msg_t src_msg,
    input wire logic snk_ack
);
    // ==========================================================
    // Helper state: request outstanding, any message yet, gap
    logic pend_q, pend_d, seen_q, seen_d;
    logic [7:0] gap_q, gap_d;
    logic min_v, rdy_v;
    assign min_v = src_msg_valid && (src_msg == MSG_GOTO_MIN);
    assign rdy_v = src_msg_valid && (src_msg == MSG_PS_READY);
    always_comb
    begin
        pend_d = (pend_q | min_v) & ~rdy_v;
        seen_d = seen_q | src_msg_valid;
        // Saturate so a long wait cannot wrap to a short gap
        gap_d = min_v ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
    end
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pend_q <= 1'h0;
            seen_q <= 1'h0;
            gap_q <= 8'h00;
        end
        else
        begin
            pend_q <= pend_d;
            seen_q <= seen_d;
            gap_q <= gap_d;
        end
    end
    // ==========================================================
    // Link properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    a_ack_with_valid: assert property (src_msg_valid |-> snk_ack)
        else $error("good reply missing for a message");
    a_ack_only_valid: assert property (snk_ack |-> src_msg_valid)
        else $error("good reply without a message");
    a_valid_one_cycle: assert property (src_msg_valid |=> !src_msg_valid)
        else $error("message held past its reply");
    a_msg_code_legal: assert property (src_msg_valid |-> (min_v || rdy_v))
        else $error("unknown message code");
    a_first_is_min: assert property (src_msg_valid && !seen_q |-> min_v)
        else $error("first message is not a reduce request");
    a_ready_needs_min: assert property (rdy_v |-> pend_q)
        else $error("ready message without a reduce request");
    a_no_dup_min: assert property (min_v |-> !pend_q)
        else $error("second reduce request while one is open");
    a_ready_gap: assert property (rdy_v |-> gap_q >= WAIT_CYC + 2)
        else $error("ready message before the transition wait");
    a_ready_quiet: assert property (rdy_v |=> !src_msg_valid [*2])
        else $error("traffic right after the ready message");
    c_min_sent: cover property (min_v);
    c_ready_sent: cover property (rdy_v);
    c_ready_tight: cover property (rdy_v && gap_q == WAIT_CYC + 2);
endmodule : gmr_link_checker

// ---- test/goto_min_power_reduction_seq_bench.sv ----
// Self-checking bench for the source and sink policy engines
`timescale 1ns/1ps
module goto_min_power_reduction_seq_bench;
    import gmr_pkg::*;
    localparam int WAIT = 4;
    localparam int SETTLE = 3;
    // Short timer values keep the run small; they do not follow the ratios of the real intervals
    localparam int READY = 20;
    localparam int TRANS = 60;
    localparam int NEW_PWR = 2;
    localparam int SRC_OFF = 80;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic start = 1'h0;
    logic supply_ready = 1'h0;
    logic supply_done = 1'h0;
    logic supply_done_b = 1'h0;
    logic swap_a = 1'h0;
    logic swap_b = 1'h1;
    logic chg_cmd, rdy_to, busy, src_done, reduce_cmd, settle_cmd, role_rdy, trans_err, snk_done;
    logic settle2, role2, done2;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    gmr_link_if link();
    gmr_link_if l2();
    // ==========================================================
    // Both ends on one link, a lone sink on a bench-driven link
    gmr_source_pe #(.WAIT_CYC(WAIT), .READY_CYC(READY)) gmr_source_pe_inst (.CORE_CLK(core_clk),
        .NRST(nrst), .LINK(link), .START(start), .SUPPLY_READY(supply_ready),
        .SUPPLY_CHANGE_CMD(chg_cmd), .READY_TIMEOUT(rdy_to), .BUSY(busy), .SEQ_DONE(src_done));
    gmr_sink_pe #(.TRANSITION_CYC(TRANS), .NEW_POWER_CYC(NEW_PWR), .SETTLE_CYC(SETTLE),
        .SRC_OFF_CYC(SRC_OFF)) gmr_sink_pe_inst (.CORE_CLK(core_clk), .NRST(nrst), .LINK(link),
        .SWAP_ACTIVE(swap_a), .SUPPLY_DONE(supply_done), .REDUCE_CMD(reduce_cmd),
        .SETTLE_CMD(settle_cmd), .SINK_ROLE_READY(role_rdy), .TRANSITION_ERR(trans_err),
        .SEQ_DONE(snk_done));
    gmr_sink_pe #(.TRANSITION_CYC(TRANS), .NEW_POWER_CYC(NEW_PWR), .SETTLE_CYC(SETTLE),
        .SRC_OFF_CYC(SRC_OFF)) gmr_sink_pe_inst_b (.CORE_CLK(core_clk), .NRST(nrst), .LINK(l2),
        .SWAP_ACTIVE(swap_b), .SUPPLY_DONE(supply_done_b), .REDUCE_CMD(),
        .SETTLE_CMD(settle2), .SINK_ROLE_READY(role2), .TRANSITION_ERR(), .SEQ_DONE(done2));
    gmr_link_checker #(.WAIT_CYC(WAIT)) gmr_link_checker_inst (.CORE_CLK(core_clk), .NRST(nrst),
        .src_msg_valid(link.src_msg_valid), .src_msg(link.src_msg), .snk_ack(link.snk_ack));
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    // ==========================================================
    // Comparison, verdict and hang guard
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            close_out();
        end
    end
    // ==========================================================
    // Reduce request, wait, supply change, ready; late supply optional
    task automatic run_min(input logic early, input int late);
        int n;
        logic red_seen, to_seen, err_seen;
        red_seen = 1'h0;
        to_seen = 1'h0;
        err_seen = 1'h0;
        @(posedge core_clk) start <= 1'h1;
        supply_done <= early;
        @(posedge core_clk) start <= 1'h0;
        @(negedge core_clk);
        check("reduce msg", {link.src_msg_valid, link.snk_ack, link.src_msg},
            4'hD);
        check("busy in run", busy, 1'h1);
        for (n = 0; n < 100 && chg_cmd !== 1'h1; n++)
        begin
            @(negedge core_clk);
            red_seen |= reduce_cmd;
        end
        check("wait length", n, WAIT + 2);
        check("load shed seen", red_seen, 1'h1);
        check("load shed over", reduce_cmd, 1'h0);
        // A second start while busy must be ignored
        @(posedge core_clk) start <= 1'h1;
        @(posedge core_clk) start <= 1'h0;
        for (n = 0; n < late; n++)
        begin
            @(negedge core_clk);
            to_seen |= rdy_to;
            err_seen |= trans_err;
        end
        @(posedge core_clk) supply_ready <= 1'h1;
        for (n = 0; n < 10 && link.src_msg_valid !== 1'h1; n++)
            @(negedge core_clk);
        check("ready msg", link.src_msg, MSG_PS_READY);
        check("change cmd off", chg_cmd, 1'h0);
        check("late flags", {to_seen, err_seen}, (late > 0) ? 2'h3 : 2'h0);
        @(posedge core_clk) supply_ready <= 1'h0;
        supply_done <= 1'h0;
        @(negedge core_clk);
        // A sink whose timer ran out is idle and ignores the late ready message
        check("both done", {src_done, snk_done, trans_err},
            (late > 0) ? 3'h4 : 3'h6);
    endtask : run_min
    // ==========================================================
    // Swap ready message to an idle sink, settle by timer or early supply report
    task automatic run_swap(input logic early);
        int n;
        @(posedge core_clk) l2.src_msg_valid <= 1'h1;
        l2.src_msg <= MSG_PS_READY;
        supply_done_b <= early;
        @(negedge core_clk);
        check("swap ack", l2.snk_ack, 1'h1);
        @(posedge core_clk) l2.src_msg_valid <= 1'h0;
        l2.src_msg <= MSG_NONE;
        @(negedge core_clk);
        // Role flag from an earlier swap drops while the new settle runs
        check("settle on", {settle2, role2}, 2'h2);
        for (n = 0; n < 20 && settle2 === 1'h1; n++)
            @(negedge core_clk);
        // Early supply report ends the settle at once, else the timer bounds it
        check("settle length", n, early ? 1 : SETTLE + 1);
        check("role and done", {role2, done2}, 2'h3);
        @(posedge core_clk) supply_done_b <= 1'h0;
    endtask : run_swap
    initial
    begin
        l2.src_msg_valid <= 1'h0;
        l2.src_msg <= MSG_NONE;
        repeat (12) @(posedge core_clk);
        nrst <= 1'h1;
        @(negedge core_clk);
        check("reset outs", {chg_cmd, rdy_to, busy, src_done, reduce_cmd, role_rdy},
            6'h0);
        check("reset sink outs", {settle_cmd, trans_err, snk_done, settle2, role2, done2},
            6'h0);
        run_min(1'h1, 0);
        run_min(1'h0, 80);
        run_swap(1'h0);
        run_swap(1'h1);
        run_min(1'h1, 0);
        close_out();
    end
endmodule : goto_min_power_reduction_seq_bench
